// *** sdcb_bank.sv ***
// Purpose: Serial word capture, channel decode and code registers for twelve channels.
// Assumes: Serial clock, select, data, preset and shutdown pins are asynchronous.
// Notes: The serial clock is oversampled, so its rate is bounded by the system clock.
`timescale 1ns/1ps
module sdcb_bank (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic SERIAL_DIN_I,
  input wire logic MIDSCALE_PRESET_N_I,
  input wire logic POWER_DOWN_N_I,
  output sdcb_pkg::sdcb_bank_type CHANNEL_CODE_O,
  output logic [sdcb_pkg::NUM_CHAN-1:0] CHANNEL_OE_O,
  output logic LOAD_DONE_O
);

  sdcb_pkg::sdcb_pins_type raw_pins;
  sdcb_pkg::sdcb_pins_type pins;

  sdcb_pkg::sdcb_state_type state_ff;
  sdcb_pkg::sdcb_state_type nxt_state;
  logic sclk_d_ff;
  logic nxt_sclk_d;
  logic [sdcb_pkg::WORD_BITS-1:0] shift_ff;
  logic [sdcb_pkg::WORD_BITS-1:0] nxt_shift;
  sdcb_pkg::sdcb_bank_type code_ff;
  sdcb_pkg::sdcb_bank_type nxt_code;
  logic [sdcb_pkg::NUM_CHAN-1:0] oe_ff;
  logic [sdcb_pkg::NUM_CHAN-1:0] nxt_oe;
  logic done_ff;
  logic nxt_done;

  logic shift_pulse;
  logic load_pulse;
  sdcb_pkg::sdcb_word_type word;

  // Decoded target: index equals address, so address zero is channel one.
  function automatic logic addr_in_range(input logic [sdcb_pkg::ADDR_BITS-1:0] a);
    addr_in_range = (a <= sdcb_pkg::LAST_ADDR);
  endfunction

  assign raw_pins = '{sclk: SCLK_I, cs_n: CS_N_I, din: SERIAL_DIN_I,
                      preset_n: MIDSCALE_PRESET_N_I, pd_n: POWER_DOWN_N_I};

  sdcb_sync u_sync (
    .CLOCK_I(CLOCK_I),
    .RST_N_I(RST_N_I),
    .pins_i(raw_pins),
    .pins_o(pins)
  );

  // The captured word keeps only the most recent twelve bits.
  assign word.addr = shift_ff[sdcb_pkg::ADDR_MSB:sdcb_pkg::ADDR_LSB];
  assign word.code = shift_ff[sdcb_pkg::CODE_MSB:sdcb_pkg::CODE_LSB];

  // Clock edges only count while select is low and the frame is open.
  assign shift_pulse = pins.sclk && !sclk_d_ff && !pins.cs_n
                       && (state_ff == sdcb_pkg::SDCB_ACTIVE);
  assign load_pulse = pins.cs_n && (state_ff == sdcb_pkg::SDCB_ACTIVE);

  always_comb begin
    // Each link clock phase must span two system clocks to be seen; a 33 MHz link is too fast
    // for this oversampling front end, which is the price of keeping a single clock domain.
    nxt_sclk_d = pins.sclk;
    nxt_state = state_ff;
    case (state_ff)
      sdcb_pkg::SDCB_IDLE: begin
        if (!pins.cs_n) begin
          nxt_state = sdcb_pkg::SDCB_ACTIVE;
        end
      end
      sdcb_pkg::SDCB_ACTIVE: begin
        if (pins.cs_n) begin
          nxt_state = sdcb_pkg::SDCB_IDLE;
        end
      end
      default: begin
        nxt_state = sdcb_pkg::SDCB_IDLE;
      end
    endcase
    if (!RST_N_I) begin
      nxt_state = sdcb_pkg::SDCB_IDLE;
      nxt_sclk_d = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    state_ff <= nxt_state;
    sclk_d_ff <= nxt_sclk_d;
  end

  // MSB arrives first, so bits enter at the bottom and move upward.
  always_comb begin
    nxt_shift = shift_ff;
    if (shift_pulse) begin
      nxt_shift = {shift_ff[sdcb_pkg::WORD_BITS-2:0], pins.din};
    end
    if (!RST_N_I) begin
      nxt_shift = '0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    shift_ff <= nxt_shift;
  end

  // Preset wins over a simultaneous load so that every channel ends at midscale.
  // Shutdown does not gate loading; the registers keep updating while outputs float.
  always_comb begin
    nxt_code = code_ff;
    nxt_done = 1'b0;
    if (load_pulse && addr_in_range(word.addr)) begin
      nxt_code.code[word.addr] = word.code;
      nxt_done = 1'b1;
    end
    if (!pins.preset_n || !RST_N_I) begin
      for (int i = 0; i < sdcb_pkg::NUM_CHAN; i++) begin
        nxt_code.code[i] = sdcb_pkg::MIDSCALE_CODE;
      end
      nxt_done = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    code_ff <= nxt_code;
    done_ff <= nxt_done;
  end

  // Output drivers stay off in shutdown; the held codes reappear on release.
  always_comb begin
    nxt_oe = pins.pd_n ? sdcb_pkg::ALL_ON : sdcb_pkg::ALL_OFF;
    if (!RST_N_I) begin
      nxt_oe = sdcb_pkg::ALL_OFF;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    oe_ff <= nxt_oe;
  end

  assign CHANNEL_CODE_O = code_ff;
  assign CHANNEL_OE_O = oe_ff;
  assign LOAD_DONE_O = done_ff;

  // Helper: last cycle's bank, held in a register so the change map stays combinational.
  sdcb_pkg::sdcb_bank_type prev_code_ff;
  sdcb_pkg::sdcb_bank_type nxt_prev_code;
  logic [sdcb_pkg::NUM_CHAN-1:0] changed;

  always_comb begin
    nxt_prev_code = code_ff;
    for (int i = 0; i < sdcb_pkg::NUM_CHAN; i++) begin
      changed[i] = (code_ff.code[i] != prev_code_ff.code[i]);
    end
  end

  always_ff @(posedge CLOCK_I) begin
    prev_code_ff <= nxt_prev_code;
  end

  // Helper: clock edges taken in the open frame. It saturates at fifteen, which is enough
  // to tell a long frame from a plain twelve-bit word.
  logic [sdcb_pkg::ADDR_BITS-1:0] bits_ff;
  logic [sdcb_pkg::ADDR_BITS-1:0] nxt_bits;

  always_comb begin
    nxt_bits = bits_ff;
    if (shift_pulse && (bits_ff != '1)) begin
      nxt_bits = bits_ff + 4'h1;
    end
    if ((state_ff == sdcb_pkg::SDCB_IDLE) || !RST_N_I) begin
      nxt_bits = '0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    bits_ff <= nxt_bits;
  end

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  chk_shift_data: assert property (
    shift_pulse |=> shift_ff == {$past(shift_ff[sdcb_pkg::WORD_BITS-2:0]), $past(pins.din)})
    else $error("Shift register did not take the data bit on a clock edge.");

  chk_idle_frozen: assert property (
    (state_ff == sdcb_pkg::SDCB_IDLE) |=> $stable(shift_ff))
    else $error("Shift register moved while select was high.");

  // The load cycle has select high while the frame is still open; nothing may shift then.
  chk_select_frozen: assert property (
    pins.cs_n |=> $stable(shift_ff))
    else $error("Shift register moved in the cycle that select was seen high.");

  chk_shift_cause: assert property (
    $changed(shift_ff) |-> !$past(pins.cs_n) && $past(pins.sclk))
    else $error("Shift register moved without a selected clock edge.");

  chk_load_target: assert property (
    (load_pulse && addr_in_range(word.addr) && pins.preset_n)
    |=> code_ff.code[$past(word.addr)] == $past(word.code) && LOAD_DONE_O)
    else $error("Addressed channel did not take the captured code.");

  chk_done_single: assert property (
    LOAD_DONE_O |=> !LOAD_DONE_O)
    else $error("Load pulse lasted more than one cycle.");

  // An out-of-range word must load nothing and report nothing.
  chk_done_valid: assert property (
    LOAD_DONE_O |-> $past(load_pulse) && ($past(word.addr) <= sdcb_pkg::LAST_ADDR))
    else $error("Load pulse without a valid captured word.");

  chk_one_channel: assert property (
    pins.preset_n && $past(pins.preset_n) |-> $countones(changed) <= 1)
    else $error("More than one channel changed on a single update.");

  // Codes move only through a load or a preset; reset is excluded by the disable.
  chk_code_cause: assert property (
    $changed(code_ff) |-> $past(load_pulse) || !$past(pins.preset_n))
    else $error("A channel code changed with neither a load nor a preset.");

  chk_bad_addr: assert property (
    (load_pulse && !addr_in_range(word.addr) && pins.preset_n)
    |=> $stable(code_ff) && !LOAD_DONE_O)
    else $error("Out-of-range address changed a channel.");

  chk_preset_mid: assert property (
    !pins.preset_n |=> code_ff == {sdcb_pkg::NUM_CHAN{sdcb_pkg::MIDSCALE_CODE}})
    else $error("Preset did not load midscale.");

  chk_preset_first: assert property (
    !pins.preset_n |=> !LOAD_DONE_O)
    else $error("A load was reported while preset was held.");

  // Reset itself is the subject here, so this check is never disabled.
  chk_reset_mid: assert property (disable iff (1'b0)
    !RST_N_I |=> code_ff == {sdcb_pkg::NUM_CHAN{sdcb_pkg::MIDSCALE_CODE}}
                 && CHANNEL_OE_O == sdcb_pkg::ALL_OFF && !LOAD_DONE_O)
    else $error("Reset did not load midscale with outputs off.");

  chk_power_down_n_float: assert property (
    !pins.pd_n |=> CHANNEL_OE_O == sdcb_pkg::ALL_OFF)
    else $error("Outputs driven during shutdown.");

  chk_wake_on: assert property (
    pins.pd_n |=> CHANNEL_OE_O == sdcb_pkg::ALL_ON)
    else $error("Outputs not driven outside shutdown.");

  chk_oe_uniform: assert property (
    CHANNEL_OE_O == sdcb_pkg::ALL_ON || CHANNEL_OE_O == sdcb_pkg::ALL_OFF)
    else $error("Output enables split between channels.");

  chk_power_down_n_hold: assert property (
    (!pins.pd_n && !load_pulse && pins.preset_n) |=> $stable(code_ff))
    else $error("Codes changed during shutdown without a load.");

  chk_wake_drive: assert property (
    $rose(pins.pd_n) && !load_pulse && pins.preset_n
    |=> CHANNEL_OE_O == sdcb_pkg::ALL_ON && $stable(code_ff))
    else $error("Outputs did not return on leaving shutdown.");

  chk_edge_spacing: assert property (
    shift_pulse |=> !shift_pulse)
    else $error("Two shift edges were taken back to back.");

  // A state outside the two codes falls back to idle on the next clock.
  chk_state_onehot: assert property (
    $onehot(state_ff))
    else $error("Frame state left its one-hot codes.");

  chk_frame_open: assert property (
    $fell(pins.cs_n) |=> state_ff == sdcb_pkg::SDCB_ACTIVE)
    else $error("Frame did not open when select fell.");

  chk_frame_close: assert property (
    load_pulse |=> state_ff == sdcb_pkg::SDCB_IDLE && !load_pulse)
    else $error("Frame did not close after the load.");

  cov_load: cover property (load_pulse && addr_in_range(word.addr) ##1 LOAD_DONE_O);
  cov_bad_addr: cover property (load_pulse && !addr_in_range(word.addr));
  cov_preset: cover property ($fell(pins.preset_n));
  cov_power_down_n_load: cover property (!pins.pd_n && load_pulse);
  cov_long_frame: cover property (load_pulse && (bits_ff > sdcb_pkg::WORD_BITS));

endmodule

// *** sdcb_host_model.sv ***
// Purpose: Serial master model that loads words into the channel bank.
// Assumes: Link clock period of 160 ns, eight system clocks.
// Notes: All pin changes happen at the falling system clock edge.
`timescale 1ns/1ps
module sdcb_host_model (
  input wire logic CLOCK_I,
  output logic SCLK_O,
  output logic CS_N_O,
  output logic DIN_O
);
  initial begin
    SCLK_O = 1'b1;
    CS_N_O = 1'b1;
    DIN_O = 1'b0;
  end

  // With sel low the clock still toggles, so a select-gating fault shows.
  task automatic send(input logic [15:0] bits, input logic long, input logic sel);
    @(negedge CLOCK_I);
    CS_N_O = ~sel;
    for (int i = long ? 15 : 11; i >= 0; i--) begin
      repeat (4) @(negedge CLOCK_I);
      SCLK_O = 1'b0;
      DIN_O = bits[i];
      repeat (4) @(negedge CLOCK_I);
      SCLK_O = 1'b1;
    end
    repeat (4) @(negedge CLOCK_I);
    CS_N_O = 1'b1;
    // The data line is not held after the frame, so it shows a changed level.
    DIN_O = ~DIN_O;
    repeat (6) @(negedge CLOCK_I);
  endtask
endmodule

// *** sdcb_pkg.sv ***
// Purpose: Shared constants and types for the serial-loaded converter channel bank.
// Assumes: System clock of 50 MHz; the serial pins are asynchronous to it.
// Notes: Every number used by the logic is named here once.
package sdcb_pkg;

  localparam int NUM_CHAN = 12;
  localparam int WORD_BITS = 12;
  localparam int CODE_BITS = 8;
  localparam int ADDR_BITS = 4;
  localparam int ADDR_MSB = 11;
  localparam int ADDR_LSB = 8;
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 0;

  localparam logic [CODE_BITS-1:0] MIDSCALE_CODE = 8'h80;
  localparam logic [ADDR_BITS-1:0] LAST_ADDR = 4'hB;
  localparam logic [NUM_CHAN-1:0] ALL_ON = 12'hFFF;
  localparam logic [NUM_CHAN-1:0] ALL_OFF = 12'h000;

  localparam int CLK_PERIOD_NS = 20;
  localparam int SCLK_MIN_PERIOD_NS = 30;
  localparam int SCLK_MIN_CYC = (SCLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef logic [CODE_BITS-1:0] sdcb_code_type;

  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    sdcb_code_type code;
  } sdcb_word_type;

  typedef struct packed {
    sdcb_code_type [NUM_CHAN-1:0] code;
  } sdcb_bank_type;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
    logic preset_n;
    logic pd_n;
  } sdcb_pins_type;

  localparam sdcb_pins_type PINS_IDLE = '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0,
                                         preset_n: 1'b1, pd_n: 1'b1};

  typedef enum logic [1:0] {
    SDCB_IDLE = 2'h1,
    SDCB_ACTIVE = 2'h2
  } sdcb_state_type;

endpackage

// *** sdcb_sync.sv ***
// Purpose: Two-stage synchroniser for a group of asynchronous pins.
// Assumes: Each bit is an independent level; no bus coherence is promised.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
module sdcb_sync (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire sdcb_pkg::sdcb_pins_type pins_i,
  output sdcb_pkg::sdcb_pins_type pins_o
);

  sdcb_pkg::sdcb_pins_type meta_ff;
  sdcb_pkg::sdcb_pins_type stable_ff;
  sdcb_pkg::sdcb_pins_type nxt_meta;
  sdcb_pkg::sdcb_pins_type nxt_stable;

  always_comb begin
    nxt_meta = pins_i;
    nxt_stable = meta_ff;
    if (!RST_N_I) begin
      nxt_meta = sdcb_pkg::PINS_IDLE;
      nxt_stable = sdcb_pkg::PINS_IDLE;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    meta_ff <= nxt_meta;
    stable_ff <= nxt_stable;
  end

  assign pins_o = stable_ff;

endmodule

// *** tb_sdcb_bank.sv ***
// Purpose: Self-checking bench for the serial channel bank.
// Assumes: The host model drives the link; the bench drives preset and shutdown.
// Notes: Expected codes live in a shadow bank.
`timescale 1ns/1ps
module tb_sdcb_bank;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic preset_n = 1'b1;
  logic pd_n = 1'b1;
  logic sclk;
  logic cs_n;
  logic din;
  logic done;
  logic [sdcb_pkg::NUM_CHAN-1:0] oe;
  sdcb_pkg::sdcb_bank_type codes;
  sdcb_pkg::sdcb_bank_type exp_bank;
  int bad_count = 0;
  int n_tests = 0;
  int done_cnt = 0;

  always #10 clock_i = ~clock_i;
  always @(posedge clock_i) if (done === 1'b1) done_cnt <= done_cnt + 1;

  sdcb_bank i_sdcb_bank (.CLOCK_I(clock_i), .RST_N_I(rst_n_i), .SCLK_I(sclk),
    .CS_N_I(cs_n), .SERIAL_DIN_I(din), .MIDSCALE_PRESET_N_I(preset_n),
    .POWER_DOWN_N_I(pd_n), .CHANNEL_CODE_O(codes), .CHANNEL_OE_O(oe), .LOAD_DONE_O(done));
  sdcb_host_model i_sdcb_host_model (.CLOCK_I(clock_i), .SCLK_O(sclk), .CS_N_O(cs_n),
    .DIN_O(din));

  task automatic fail(input string msg);
    $display("CHECK FAILED at %0t: %s", $time, msg);
    bad_count++;
  endtask

  task automatic chk_bank(input int n_done);
    n_tests += 2;
    if (codes !== exp_bank) fail("channel codes differ");
    if (done_cnt != n_done) fail("load pulse count wrong");
  endtask

  task automatic chk_oe(input logic [sdcb_pkg::NUM_CHAN-1:0] e);
    repeat (5) @(negedge clock_i);
    n_tests++;
    if (oe !== e) fail("output enables wrong");
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] c, input logic long);
    int n;
    n = done_cnt;
    i_sdcb_host_model.send({long ? 4'hF : 4'h0, a, c}, long, 1'b1);
    if (a <= sdcb_pkg::LAST_ADDR) begin
      exp_bank.code[a] = c;
      n++;
    end
    chk_bank(n);
  endtask

  task automatic t_reset;
    chk_oe(sdcb_pkg::ALL_ON);
    chk_bank(0);
    $display("test reset finished");
  endtask

  task automatic t_chans;
    for (int a = 11; a >= 0; a--) wr(4'(a), 8'(a * 23), 1'b0);
    for (int a = 0; a < 12; a++) wr(4'(a), 8'(8'hFF - a), 1'b0);
    $display("test channels finished");
  endtask

  task automatic t_odd;
    int n;
    for (int a = 12; a < 16; a++) wr(4'(a), 8'h33, 1'b0);
    wr(4'h3, 8'hA5, 1'b1);
    n = done_cnt;
    i_sdcb_host_model.send(16'h0A5A, 1'b0, 1'b0);
    chk_bank(n);
    $display("test odd frames finished");
  endtask

  task automatic t_preset;
    @(negedge clock_i);
    preset_n = 1'b0;
    repeat (5) @(negedge clock_i);
    exp_bank = {sdcb_pkg::NUM_CHAN{sdcb_pkg::MIDSCALE_CODE}};
    chk_bank(done_cnt);
    preset_n = 1'b1;
    wr(4'hB, 8'h01, 1'b0);
    $display("test preset finished");
  endtask

  task automatic t_shutdown;
    @(negedge clock_i);
    pd_n = 1'b0;
    chk_oe(sdcb_pkg::ALL_OFF);
    wr(4'h7, 8'hC3, 1'b0);
    wr(4'h0, 8'h00, 1'b0);
    chk_oe(sdcb_pkg::ALL_OFF);
    pd_n = 1'b1;
    chk_oe(sdcb_pkg::ALL_ON);
    chk_bank(done_cnt);
    $display("test shutdown finished");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    exp_bank = {sdcb_pkg::NUM_CHAN{sdcb_pkg::MIDSCALE_CODE}};
    repeat (10) @(negedge clock_i);
    rst_n_i = 1'b1;
    t_reset;
    t_chans;
    t_odd;
    t_preset;
    t_shutdown;
    print_verdict;
  end

  initial begin
    #1ms;
    fail("run did not finish in time");
    print_verdict;
  end
endmodule
